// File: rtl/ebid_alu.v
`timescale 1ns/1ns
`default_nettype none
`include "ebid_consts.vh"

module ebid_alu (
	// Operation select and operands.
	input  wire [3:0] op,
	input  wire [7:0] x,
	input  wire [7:0] y,
	input  wire       cin,
	// Result and flag candidates.
	output reg  [7:0] res,
	output reg        cout,
	output reg        hcout,
	output wire       zout
);

	// Full sums for addition and for two's complement subtraction x - y.
	wire [8:0] add9 = {1'b0, x} + {1'b0, y};
	wire [4:0] addh = {1'b0, x[3:0]} + {1'b0, y[3:0]};
	wire [8:0] sub9 = {1'b0, x} + {1'b0, ~y} + 9'h001;
	wire [4:0] subh = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + 5'h01;

	// The zero candidate always follows the selected result.
	assign zout = (res == 8'h00);

	// Selects the result and carry candidates for the requested operation.
	always @* begin
		res   = x;
		cout  = cin;
		hcout = 1'b0;
		case (op)
			`EBID_ALU_ADD: begin
				res   = add9[7:0];
				cout  = add9[8];
				hcout = addh[4];
			end
			`EBID_ALU_SUB: begin
				// Carry set means no borrow occurred.
				res   = sub9[7:0];
				cout  = sub9[8];
				hcout = subh[4];
			end
			`EBID_ALU_AND:  res = x & y;
			`EBID_ALU_OR:   res = x | y;
			`EBID_ALU_XOR:  res = x ^ y;
			`EBID_ALU_COM:  res = ~x;
			`EBID_ALU_DEC:  res = x + 8'hff;
			`EBID_ALU_INC:  res = x + 8'h01;
			`EBID_ALU_RLC: begin
				res  = {x[6:0], cin};
				cout = x[7];
			end
			`EBID_ALU_RRC: begin
				res  = {cin, x[7:1]};
				cout = x[0];
			end
			`EBID_ALU_SWAP: res = {x[3:0], x[7:4]};
			`EBID_ALU_ZERO: res = 8'h00;
			default:        res = x;
		endcase
	end

endmodule
`default_nettype wire

// File: rtl/ebid_bitop.v
`timescale 1ns/1ns
`default_nettype none

module ebid_bitop (
	// Operand byte and selected bit position.
	input  wire [7:0] data,
	input  wire [2:0] idx,
	// Byte with the bit forced low or high, and the bit itself.
	output wire [7:0] cleared,
	output wire [7:0] set,
	output wire       bit_val
);

	// One-hot mask of the selected bit.
	wire [7:0] mask = 8'h01 << idx;

	assign cleared = data & ~mask;
	assign set     = data | mask;
	assign bit_val = |(data & mask);

endmodule
`default_nettype wire

// File: rtl/ebid_consts.vh
`ifndef EBID_CONSTS_VH
`define EBID_CONSTS_VH

// Reset value of the program counter.
`define EBID_PC_RESET      13'h0000
// Increment applied to the program counter for each sequential fetch.
`define EBID_PC_STEP       13'h0001
// Instruction word that executes as a no-operation (flush filler).
`define EBID_NOP_WORD      14'h0000
// Reset value of the accumulator.
`define EBID_ACC_RESET     8'h00
// File address of the timer-zero count register.
`define EBID_TIMER_ADDR    7'h01
// File address of the I/O port whose reads come from the pins.
`define EBID_PORT_ADDR     7'h05
// Reset value of the file write address.
`define EBID_ADDR_RESET    7'h00

// Field positions inside the 14-bit instruction word.
`define EBID_DEST_BIT      7
`define EBID_FADDR_MSB     6
`define EBID_BIDX_MSB      9
`define EBID_BIDX_LSB      7
`define EBID_LIT8_MSB      7
`define EBID_LIT11_MSB     10

// Arithmetic and logic unit operation codes.
`define EBID_ALU_PASS      4'h0
`define EBID_ALU_ADD       4'h1
`define EBID_ALU_SUB       4'h2
`define EBID_ALU_AND       4'h3
`define EBID_ALU_OR        4'h4
`define EBID_ALU_XOR       4'h5
`define EBID_ALU_COM       4'h6
`define EBID_ALU_DEC       4'h7
`define EBID_ALU_INC       4'h8
`define EBID_ALU_RLC       4'h9
`define EBID_ALU_RRC       4'ha
`define EBID_ALU_SWAP      4'hb
`define EBID_ALU_ZERO      4'hc

`endif

// File: rtl/ebid_core.v
// Overview of operation
// - Destination bit picks accumulator or file.
// - Add and file-minus-acc update C, DC, Z.
// - Literal add and subtract update C, DC, Z.
// - Logical acc-with-file ops affect only zero.
// - Logical literal ops write acc, affect zero.
// - Don't-care encoding bits never change behaviour.
// - Invert, decrement, increment, copy affect only zero.
// - Rotates touch carry; nibble exchange no flags.
// - Clear file/acc set zero; store acc.
// - Step-and-skip ops skip when result zero.
// - Bit clear and set change no flags.
// - Bit tests discard next word when true.
// - Call pushes return, loads latched target.
// - Jump loads latched target, pushes nothing.
// - Watchdog clear resets counter, sets both bits.
// - Port reads use pin levels, not latch.
// - Timer-zero write clears its assigned prescaler.
// - Redirects and true tests take two cycles.
// - Operand fields decode at their full widths.
// - Interrupt return pops and sets interrupt enable.
// - Returns pop; literal return also loads acc.
// - Sleep clears watchdog, sets time-out, halts.
`timescale 1ns/1ns
`default_nettype none
`include "ebid_consts.vh"

module ebid_core (
	// Clock and synchronous active-low reset.
	input  wire        clk_sys,
	input  wire        resetn,
	// Program memory fetch.
	output reg  [12:0] pc_r,
	input  wire [13:0] instr_word,
	input  wire [4:0]  upper_address_latch,
	// File register read port.
	output reg  [6:0]  file_addr_r,
	input  wire [7:0]  file_rdata,
	input  wire [7:0]  port_pin_levels,
	// File register write port.
	output reg         file_we_r,
	output reg  [6:0]  file_wr_addr_r,
	output reg  [7:0]  file_wdata_r,
	// Return stack.
	output reg         stack_push_r,
	output reg  [12:0] stack_push_data_r,
	output reg         stack_pop_r,
	input  wire [12:0] stack_top,
	// Watchdog, timer, interrupt and sleep control.
	input  wire        prescaler_on_timer,
	input  wire        wake_req,
	output reg         watchdog_clear_r,
	output reg         timer_psc_clear_r,
	output reg         global_interrupt_enable_set_r,
	output reg         sleeping_r,
	// Core state.
	output reg  [7:0]  acc_r,
	output reg         carry_r,
	output reg         half_carry_flag_r,
	output reg         zero_r,
	output reg         timeout_status_bit_r,
	output reg         powerdown_status_bit_r
);

	// Word now executing; a flush loads the no-operation word.
	reg  [13:0] instr_r;

	// Decoded operand fields at their full widths.
	// operand field widths
	wire        dest_file = instr_r[`EBID_DEST_BIT];
	wire [7:0]  lit8      = instr_r[`EBID_LIT8_MSB:0];
	wire [10:0] lit11     = instr_r[`EBID_LIT11_MSB:0];
	wire [2:0]  bit_idx   = instr_r[`EBID_BIDX_MSB:`EBID_BIDX_LSB];

	// Latest value of the addressed file, with the pending write forwarded.
	wire [7:0]  file_fwd;
	// Value used as the file operand.
	wire [7:0]  file_val;

	// Decode results.
	reg  [3:0]  alu_op;        // Operation for the arithmetic unit.
	reg  [7:0]  opx;           // First arithmetic operand.
	reg  [7:0]  opy;           // Second arithmetic operand.
	reg         wr_acc;        // Result goes to the accumulator.
	reg         wr_file;       // Result goes to the addressed file.
	reg         upd_c;         // Carry takes the unit's carry.
	reg         upd_dc;        // Half carry takes the unit's half carry.
	reg         upd_z;         // Zero takes the unit's zero.
	reg         skip_on_zero;  // Skip when the result is zero.
	reg         skip_on_bit;   // Skip when the tested bit matches.
	reg         skip_bit_val;  // Bit value that causes the skip.
	reg         bit_clr;       // File result is the bit-cleared byte.
	reg         bit_set;       // File result is the bit-set byte.
	reg         do_jump;       // Absolute jump.
	reg         do_call;       // Subroutine call.
	reg         do_ret;        // Pop the return address.
	reg         do_retie;      // Pop and re-enable interrupts.
	reg         do_sleep;      // Enter sleep.
	reg         do_wdog;       // Clear the watchdog.

	// Arithmetic unit and bit unit outputs.
	wire [7:0]  alu_res;
	wire        alu_c;
	wire        alu_dc;
	wire        alu_z;
	wire [7:0]  bit_cleared;
	wire [7:0]  bit_setbyte;
	wire        bit_now;

	// Combined control terms.
	wire        skip_now;
	wire        redirect;
	wire [12:0] branch_target;
	wire [7:0]  wr_value;

	// A write issued last cycle has not reached the memory read port yet.
	assign file_fwd = (file_we_r && (file_wr_addr_r == file_addr_r)) ?
		file_wdata_r : file_rdata;

	assign file_val = (file_addr_r == `EBID_PORT_ADDR) ?
		port_pin_levels : file_fwd;

	// Arithmetic and logic unit.
	ebid_alu u_alu (
		.op    (alu_op),
		.x     (opx),
		.y     (opy),
		.cin   (carry_r),
		.res   (alu_res),
		.cout  (alu_c),
		.hcout (alu_dc),
		.zout  (alu_z)
	);

	// Bit select, force and test unit.
	ebid_bitop u_bitop (
		.data    (file_val),
		.idx     (bit_idx),
		.cleared (bit_cleared),
		.set     (bit_setbyte),
		.bit_val (bit_now)
	);

	// Decodes the executing word into operation controls.
	always @* begin
		alu_op       = `EBID_ALU_PASS;
		opx          = file_val;
		opy          = acc_r;
		wr_acc       = 1'b0;
		wr_file      = 1'b0;
		upd_c        = 1'b0;
		upd_dc       = 1'b0;
		upd_z        = 1'b0;
		skip_on_zero = 1'b0;
		skip_on_bit  = 1'b0;
		skip_bit_val = 1'b0;
		bit_clr      = 1'b0;
		bit_set      = 1'b0;
		do_jump      = 1'b0;
		do_call      = 1'b0;
		do_ret       = 1'b0;
		do_retie     = 1'b0;
		do_sleep     = 1'b0;
		do_wdog      = 1'b0;
		casez (instr_r)
			14'b00_0000_1???_????: begin
				opx     = acc_r;
				wr_file = 1'b1;
			end
			14'b00_0000_0000_1000: do_ret = 1'b1;
			14'b00_0000_0000_1001: begin
				do_ret   = 1'b1;
				do_retie = 1'b1;
			end
			14'b00_0000_0110_0100: do_wdog = 1'b1;
			14'b00_0000_0110_0011: do_sleep = 1'b1;
			// No-operation: nothing changes.
			14'b00_0000_0??0_0000: alu_op = `EBID_ALU_PASS;
			14'b00_0001_1???_????: begin
				alu_op  = `EBID_ALU_ZERO;
				wr_file = 1'b1;
				upd_z   = 1'b1;
			end
			14'b00_0001_0???_????: begin
				alu_op = `EBID_ALU_ZERO;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b00_0010_????_????: begin
				alu_op = `EBID_ALU_SUB;
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b00_0111_????_????: begin
				alu_op = `EBID_ALU_ADD;
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b00_0100_????_????: begin
				alu_op = `EBID_ALU_OR;
				upd_z  = 1'b1;
			end
			14'b00_0101_????_????: begin
				alu_op = `EBID_ALU_AND;
				upd_z  = 1'b1;
			end
			14'b00_0110_????_????: begin
				alu_op = `EBID_ALU_XOR;
				upd_z  = 1'b1;
			end
			14'b00_0011_????_????: begin
				alu_op = `EBID_ALU_DEC;
				upd_z  = 1'b1;
			end
			14'b00_1000_????_????: begin
				alu_op = `EBID_ALU_PASS;
				upd_z  = 1'b1;
			end
			14'b00_1001_????_????: begin
				alu_op = `EBID_ALU_COM;
				upd_z  = 1'b1;
			end
			14'b00_1010_????_????: begin
				alu_op = `EBID_ALU_INC;
				upd_z  = 1'b1;
			end
			14'b00_1011_????_????: begin
				alu_op       = `EBID_ALU_DEC;
				skip_on_zero = 1'b1;
			end
			14'b00_1111_????_????: begin
				alu_op       = `EBID_ALU_INC;
				skip_on_zero = 1'b1;
			end
			14'b00_1100_????_????: begin
				alu_op = `EBID_ALU_RRC;
				upd_c  = 1'b1;
			end
			14'b00_1101_????_????: begin
				alu_op = `EBID_ALU_RLC;
				upd_c  = 1'b1;
			end
			14'b00_1110_????_????: alu_op = `EBID_ALU_SWAP;
			14'b01_00??_????_????: begin
				bit_clr = 1'b1;
				wr_file = 1'b1;
			end
			14'b01_01??_????_????: begin
				bit_set = 1'b1;
				wr_file = 1'b1;
			end
			14'b01_10??_????_????: begin
				skip_on_bit  = 1'b1;
				skip_bit_val = 1'b0;
			end
			14'b01_11??_????_????: begin
				skip_on_bit  = 1'b1;
				skip_bit_val = 1'b1;
			end
			14'b10_0???_????_????: do_call = 1'b1;
			14'b10_1???_????_????: do_jump = 1'b1;
			// Load literal into the accumulator.
			14'b11_00??_????_????: begin
				opx    = lit8;
				wr_acc = 1'b1;
			end
			14'b11_01??_????_????: begin
				opx    = lit8;
				wr_acc = 1'b1;
				do_ret = 1'b1;
			end
			14'b11_1000_????_????: begin
				alu_op = `EBID_ALU_OR;
				opx    = lit8;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b11_1001_????_????: begin
				alu_op = `EBID_ALU_AND;
				opx    = lit8;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b11_1010_????_????: begin
				alu_op = `EBID_ALU_XOR;
				opx    = lit8;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b11_110?_????_????: begin
				alu_op = `EBID_ALU_SUB;
				opx    = lit8;
				wr_acc = 1'b1;
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			14'b11_111?_????_????: begin
				alu_op = `EBID_ALU_ADD;
				opx    = lit8;
				wr_acc = 1'b1;
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			default: alu_op = `EBID_ALU_PASS;
		endcase
		if (instr_r[13:12] == 2'b00 && instr_r[11:8] != 4'b0000 &&
			instr_r[11:8] != 4'b0001) begin
			wr_acc  = ~dest_file;
			wr_file = dest_file;
		end
	end

	assign skip_now = (skip_on_zero && alu_z) ||
		(skip_on_bit && (bit_now == skip_bit_val));
	assign redirect = do_jump || do_call || do_ret;
	assign branch_target = {upper_address_latch[4:3], lit11};
	// Bit operations write the forced byte; others write the unit result.
	assign wr_value = bit_clr ? bit_cleared :
		(bit_set ? bit_setbyte : alu_res);

	// Fetch, flush and program counter sequencing.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			pc_r        <= `EBID_PC_RESET;
			instr_r     <= `EBID_NOP_WORD;
			file_addr_r <= `EBID_ADDR_RESET;
			sleeping_r  <= 1'b0;
		end else if (sleeping_r && !wake_req) begin
			// Halted: hold the counter and run no-operations.
			instr_r <= `EBID_NOP_WORD;
		end else if (do_sleep) begin
			sleeping_r <= 1'b1;
			instr_r    <= `EBID_NOP_WORD;
		end else if (redirect) begin
			pc_r    <= do_ret ? stack_top : branch_target;
			instr_r <= `EBID_NOP_WORD;
		end else if (skip_now) begin
			pc_r    <= pc_r + `EBID_PC_STEP;
			instr_r <= `EBID_NOP_WORD;
		end else begin
			sleeping_r  <= 1'b0;
			pc_r        <= pc_r + `EBID_PC_STEP;
			instr_r     <= instr_word;
			file_addr_r <= instr_word[`EBID_FADDR_MSB:0];
		end
	end

	// Accumulator, flags and file write-back.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			acc_r              <= `EBID_ACC_RESET;
			carry_r            <= 1'b0;
			half_carry_flag_r  <= 1'b0;
			zero_r             <= 1'b0;
			file_we_r          <= 1'b0;
			file_wr_addr_r     <= `EBID_ADDR_RESET;
			file_wdata_r       <= `EBID_ACC_RESET;
			timer_psc_clear_r  <= 1'b0;
		end else begin
			if (wr_acc) begin
				acc_r <= alu_res;
			end
			// Flags change only where the operation names them.
			if (upd_c) begin
				carry_r <= alu_c;
			end
			if (upd_dc) begin
				half_carry_flag_r <= alu_dc;
			end
			if (upd_z) begin
				zero_r <= alu_z;
			end
			file_we_r      <= wr_file;
			file_wr_addr_r <= file_addr_r;
			file_wdata_r   <= wr_value;
			timer_psc_clear_r  <= wr_file && prescaler_on_timer &&
				(file_addr_r == `EBID_TIMER_ADDR);
		end
	end

	// Stack, watchdog, interrupt enable and power status.
	always @(posedge clk_sys) begin
		if (!resetn) begin
			stack_push_r                  <= 1'b0;
			stack_push_data_r             <= `EBID_PC_RESET;
			stack_pop_r                   <= 1'b0;
			watchdog_clear_r              <= 1'b0;
			global_interrupt_enable_set_r <= 1'b0;
			timeout_status_bit_r          <= 1'b1;
			powerdown_status_bit_r        <= 1'b1;
		end else begin
			stack_push_r      <= do_call;
			stack_push_data_r <= pc_r;
			stack_pop_r <= do_ret;
			global_interrupt_enable_set_r <= do_retie;
			watchdog_clear_r <= do_wdog || do_sleep;
			if (do_wdog) begin
				timeout_status_bit_r   <= 1'b1;
				powerdown_status_bit_r <= 1'b1;
			end else if (do_sleep) begin
				timeout_status_bit_r   <= 1'b1;
				powerdown_status_bit_r <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// File: verif/ebid_core_properties.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks on the decoder core.
module ebid_core_properties (
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        resetn,
	// Fetch and return stack.
	input wire logic [12:0] pc_r,
	input wire logic [4:0]  upper_address_latch,
	input wire logic        stack_push_r,
	input wire logic [12:0] stack_push_data_r,
	input wire logic        stack_pop_r,
	input wire logic [12:0] stack_top,
	// File writes and timer prescaler.
	input wire logic        file_we_r,
	input wire logic [6:0]  file_wr_addr_r,
	input wire logic        prescaler_on_timer,
	input wire logic        timer_psc_clear_r,
	// Watchdog, sleep and interrupt enable.
	input wire logic        wake_req,
	input wire logic        watchdog_clear_r,
	input wire logic        global_interrupt_enable_set_r,
	input wire logic        sleeping_r,
	input wire logic        timeout_status_bit_r,
	input wire logic        powerdown_status_bit_r
);
	default clocking chk_cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// A call or return redirect shows as a stack push or pop; a jump shows as neither.
	sequence redirect_s;
		stack_push_r || stack_pop_r;
	endsequence
	// The filler cycle after a redirect leaves no trace at the ports.
	sequence flush_s;
		!file_we_r && !stack_push_r && !stack_pop_r;
	endsequence
	// A call saves the next address and takes its upper bits from the latch.
	call_target_a: assert property (stack_push_r |->
		stack_push_data_r == $past(pc_r) &&
		pc_r[12:11] == $past(upper_address_latch[4:3]))
		else $error("call target or return address wrong");
	return_target_a: assert property (stack_pop_r |->
		pc_r == $past(stack_top))
		else $error("return did not load the stack top");
	two_cycle_a: assert property (redirect_s |=> flush_s)
		else $error("second cycle of a redirect was not idle");
	gie_pop_a: assert property (global_interrupt_enable_set_r |->
		stack_pop_r)
		else $error("interrupt enable set without a pop");
	wdog_clear_a: assert property (watchdog_clear_r && !sleeping_r |->
		timeout_status_bit_r && powerdown_status_bit_r)
		else $error("watchdog clear left a status bit low");
	sleep_entry_a: assert property ($rose(sleeping_r) |->
		watchdog_clear_r && timeout_status_bit_r && !powerdown_status_bit_r)
		else $error("sleep entry side effects wrong");
	sleep_hold_a: assert property (sleeping_r && !wake_req |=>
		sleeping_r && $stable(pc_r))
		else $error("core moved while asleep");
	wake_exit_a: assert property (sleeping_r && wake_req |=>
		!sleeping_r)
		else $error("wake request did not end sleep");
	presc_clear_a: assert property (file_we_r &&
		file_wr_addr_r == 7'h01 && $past(prescaler_on_timer) |->
		timer_psc_clear_r)
		else $error("timer write kept the prescaler");
	presc_cause_a: assert property (timer_psc_clear_r |->
		file_we_r && file_wr_addr_r == 7'h01)
		else $error("prescaler cleared without a timer write");
endmodule
`default_nettype wire

// File: verif/ebid_prog_env.sv
`timescale 1ns/1ns
`default_nettype none
// Program memory, file registers and return stack facing the core.
module ebid_prog_env (
	// Clock.
	input  wire logic        clk_sys,
	// Program fetch, answered in the same cycle.
	input  wire logic [12:0] pc_r,
	output      logic [13:0] instr_word,
	// File read and write ports.
	input  wire logic [6:0]  file_addr_r,
	output      logic [7:0]  file_rdata,
	input  wire logic        file_we_r,
	input  wire logic [6:0]  file_wr_addr_r,
	input  wire logic [7:0]  file_wdata_r,
	// Return stack.
	input  wire logic        stack_push_r,
	input  wire logic [12:0] stack_push_data_r,
	input  wire logic        stack_pop_r,
	output      logic [12:0] stack_top
);
	logic [13:0] rom [0:8191]; // Program words, loaded by the bench.
	logic [7:0]  fmem [0:127]; // File register contents.
	logic [12:0] stk [0:7];    // Saved return addresses.
	logic [2:0]  sp;           // Next free stack slot.
	assign instr_word = rom[pc_r];
	assign file_rdata = fmem[file_addr_r];
	assign stack_top  = stk[sp - 3'h1];
	// Empty program executes as fillers; file space starts cleared.
	initial begin
		sp = 3'h0;
		for (int i = 0; i < 8192; i++)
			rom[i] = 14'h0000;
		for (int i = 0; i < 128; i++)
			fmem[i] = 8'h00;
	end
	// Writes land on the strobe edge, since the core forwards its own.
	always @(posedge clk_sys) begin
		if (file_we_r)
			fmem[file_wr_addr_r] <= file_wdata_r;
		if (stack_push_r) begin
			stk[sp] <= stack_push_data_r;
			sp <= sp + 3'h1;
		end
		if (stack_pop_r)
			sp <= sp - 3'h1;
	end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// Compares a seen value with the expected one and counts the outcome.
`define check_eq(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
	bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
	logic        clk_sys, resetn, prescaler_on_timer, wake_req;
	logic [4:0]  upper_address_latch;
	logic [7:0]  port_pin_levels, file_rdata, file_wdata_r, acc_r;
	logic [12:0] pc_r, stack_push_data_r, stack_top;
	logic [13:0] instr_word;
	logic [6:0]  file_addr_r, file_wr_addr_r;
	logic        file_we_r, stack_push_r, stack_pop_r, watchdog_clear_r;
	logic        timer_psc_clear_r, global_interrupt_enable_set_r;
	logic        sleeping_r, carry_r, half_carry_flag_r, zero_r;
	logic        timeout_status_bit_r, powerdown_status_bit_r;
	int          bad_count, tests_run;        // Outcome counters.
	int          gie_seen, wdog_seen;         // Control pulse counters.
	logic [31:0] seed = 32'h5507_15e3;        // Xorshift state.
	logic [13:0] w;                           // Word under test.
	logic [7:0]  a, init, e_acc, e_f;         // Operands and expectations.
	logic [6:0]  f;                           // File operand address.
	logic        c0, e_c, e_dc, e_z, e_skip, e_w;
	ebid_core ebid_core_inst (.*);
	ebid_prog_env env (.*);
	// Repeatable pseudo-random source.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Reset for rst cycles, then run n cycles; inputs move on falling edges.
	task automatic run(input int rst, input int n);
		@(negedge clk_sys) resetn = 1'b0;
		repeat (rst) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (n) @(negedge clk_sys);
	endtask
	// Expected outcome of one word from accumulator a, operand v, carry c.
	function automatic void ref_exec(input logic [13:0] w,
		input logic [7:0] a, v, input logic c);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] x, m, r;
		logic       ar, sb, zf;
		x = w[13] ? w[7:0] : v;
		m = 8'h01 << w[9:7];
		r = x;
		ar = 1'b0;
		sb = 1'b0;
		e_acc = a;
		e_c = c;
		e_dc = c;
		e_z = a == 8'h00;
		e_skip = 1'b0;
		casez (w[13:8])
		6'b00_0111, 6'b11_111?: ar = 1'b1;
		6'b00_0010, 6'b11_110?: sb = 1'b1;
		6'b00_0101, 6'b11_1001: r = a & x;
		6'b00_0100, 6'b11_1000: r = a | x;
		6'b00_0110, 6'b11_1010: r = a ^ x;
		6'b00_1001: r = ~x;
		6'b00_0011, 6'b00_1011: r = x - 8'h01;
		6'b00_1010, 6'b00_1111: r = x + 8'h01;
		6'b00_1101: r = {x[6:0], c};
		6'b00_1100: r = {c, x[7:1]};
		6'b00_1110: r = {x[3:0], x[7:4]};
		6'b00_0001: r = 8'h00;
		6'b00_0000: r = a;
		6'b01_00??: r = x & ~m;
		6'b01_01??: r = x | m;
		6'b01_1???: e_skip = |(x & m) == w[10];
		default: ;
		endcase
		// Both subtracts add the inverse plus one; carry means no borrow.
		if (ar || sb) begin
			s = {1'b0, x} + {1'b0, sb ? ~a : a} + 9'(sb);
			h = {1'b0, x[3:0]} + {1'b0, sb ? ~a[3:0] : a[3:0]} + 5'(sb);
			r = s[7:0];
			e_c = s[8];
			e_dc = h[4];
		end
		if (w[13:9] == 5'b00_110)
			e_c = w[8] ? x[7] : x[0];
		if (w[13:8] ==? 6'b00_1?11)
			e_skip = r == 8'h00;
		zf = (w[13:12] == 2'b00 && !(w[11:8] inside {4'hb, 4'hc, 4'hd,
			4'he, 4'hf, 4'h0})) || (w[13:12] == 2'b11 &&
			w[11:10] != 2'b00 && w[11:8] != 4'hb);
		if (zf)
			e_z = r == 8'h00;
		if (w[13:12] == 2'b00 ? !w[7] : w[13:12] == 2'b11 && w[11:8] != 4'hb)
			e_acc = r;
		e_w = w[13:12] == 2'b00 ? w[7] : w[13:11] == 3'b010;
		e_f = r;
	endfunction
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Counts one-cycle control pulses; each is seen at exactly one edge.
	always @(posedge clk_sys) begin
		if (global_interrupt_enable_set_r === 1'b1)
			gie_seen <= gie_seen + 1;
		if (watchdog_clear_r === 1'b1)
			wdog_seen <= wdog_seen + 1;
	end
	// Whole run is near 2260 cycles; this cuts off a hang well beyond it.
	initial begin
		#100000;
		bad_count++;
		finish_test();
	end
	initial begin
		resetn = 1'b0;
		wake_req = 1'b0;
		prescaler_on_timer = 1'b0;
		upper_address_latch = 5'h00;
		port_pin_levels = 8'h00;
		run(20, 1);
		// Random words: carry preset, operand word, then a skip marker.
		for (int t = 0; t < 200; t++) begin
			do
				w = 14'(rnd());
			while (w[13:12] == 2'b10 || w[13:7] == 7'h00 ||
				w[13:10] == 4'b1101);
			case (rnd() & 32'h0000_0003)
			0: f = 7'h01;
			1: f = 7'h05;
			default: f = 7'h20 + 7'(rnd() & 32'h0000_003f);
			endcase
			if (!w[13])
				w[6:0] = f;
			a = 8'(rnd());
			c0 = 1'(rnd());
			init = 8'(rnd());
			port_pin_levels = 8'(rnd());
			prescaler_on_timer = 1'(rnd());
			upper_address_latch = 5'(rnd());
			env.fmem[f] = init;
			env.fmem[7'h70] = 8'h00;
			env.rom[0] = {c0 ? 6'b11_1100 : 6'b11_1110, a};
			env.rom[1] = w;
			env.rom[2] = 14'h1470;
			run(2, 8);
			ref_exec(w, a, (f == 7'h05 && !w[13]) ? port_pin_levels : init, c0);
			`check_eq("acc", e_acc, acc_r)
			`check_eq("flags", {e_c, e_dc, e_z}, {carry_r, half_carry_flag_r, zero_r})
			`check_eq("file", e_w ? e_f : init, env.fmem[f])
			`check_eq("skip", !e_skip, env.fmem[7'h70][0])
			$display("test %0d word %h done", t, w);
		end
		// Jump, call, literal return, interrupt return, watchdog, sleep.
		upper_address_latch = 5'b0_1000;
		env.fmem[7'h71] = 8'h00;
		env.fmem[7'h72] = 8'h00;
		env.fmem[7'h73] = 8'h00;
		env.rom[0] = 14'h2810;
		env.rom[1] = 14'h1472;
		env.rom[13'h0810] = 14'h2020;
		env.rom[13'h0820] = 14'h3444;
		env.rom[13'h0821] = 14'h1472;
		env.rom[13'h0811] = 14'h00f1;
		env.rom[13'h0812] = 14'h2030;
		env.rom[13'h0830] = 14'h0009;
		env.rom[13'h0831] = 14'h1472;
		env.rom[13'h0813] = 14'h0064;
		env.rom[13'h0814] = 14'h0063;
		env.rom[13'h0815] = 14'h305a;
		env.rom[13'h0816] = 14'h00f3;
		run(2, 24);
		`check_eq("returned acc", 8'h44, env.fmem[7'h71])
		`check_eq("discarded words", 8'h00, env.fmem[7'h72])
		`check_eq("sleep state", 3'b110, {sleeping_r, timeout_status_bit_r, powerdown_status_bit_r})
		`check_eq("interrupt enable pulses", 1, gie_seen)
		`check_eq("watchdog clears", 2, wdog_seen)
		wake_req = 1'b1;
		@(negedge clk_sys) wake_req = 1'b0;
		repeat (6) @(negedge clk_sys);
		`check_eq("after wake", 9'h05a, {sleeping_r, env.fmem[7'h73]})
		$display("control flow test done");
		finish_test();
	end
endmodule
bind ebid_core ebid_core_properties ebid_core_properties_inst (.*);
`default_nettype wire
